// File: verilog/input_undervoltage_fault_handler.sv
`timescale 1ns/1ps
module input_undervoltage_fault_handler #(
    parameter int UNIT_W = uv_fault_pkg::DEF_UNIT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire uv_fault_pkg::cmd_t cmd,
    output uv_fault_pkg::rsp_t rsp,
    input wire logic [15:0] vin_level,
    input wire logic [UNIT_W-1:0] delay_unit_cycles,
    input wire logic ratio_regulation_enable,
    input wire logic on_command,
    input wire logic clear_faults,
    input wire logic status_clear,
    input wire logic other_fault_shutdown,
    output logic power_enable,
    output logic warning_flag,
    output logic fault_flag,
    output logic ratio_regulation_active,
    output logic latched_off
);
    import uv_fault_pkg::*;

    logic [15:0] input_low_warning_threshold;
    logic [15:0] input_low_fault_threshold;
    logic [7:0] input_low_fault_reaction;
    uv_state_t state;
    uv_state_t next_state;
    logic [2:0] attempts_left;
    logic vin_fault;
    logic timer_start;
    logic timer_done;
    logic [1:0] reaction;
    logic [2:0] retries;
    logic [2:0] delay_shift;
    logic fault_clear;

    function automatic logic retries_forever(input logic [2:0] setting);
        retries_forever = (setting == RETRY_FOREVER);
    endfunction

    generate
        if (UNIT_W < 1 || UNIT_W > 32) begin : g_bad_width
            $error("input_undervoltage_fault_handler: UNIT_W out of range");
        end
    endgenerate

    assign reaction = input_low_fault_reaction[REACT_HI:REACT_LO];
    assign retries = input_low_fault_reaction[RETRY_HI:RETRY_LO];
    assign delay_shift = input_low_fault_reaction[DELAY_HI:DELAY_LO];
    assign fault_clear = clear_faults | status_clear;

    // command port: one answer per request, unknown codes are refused
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_low_warning_threshold <= WARN_LIMIT_RESET;
            input_low_fault_threshold <= FAULT_LIMIT_RESET;
            input_low_fault_reaction <= REACTION_RESET;
        end else if (cmd.valid && cmd.write) begin
            case (cmd.code)
                CMD_WARN_LIMIT: input_low_warning_threshold <= cmd.wdata;
                CMD_FAULT_LIMIT: input_low_fault_threshold <= cmd.wdata;
                CMD_FAULT_REACTION: input_low_fault_reaction <= cmd.wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= cmd.valid;
            rsp.ack <= 1'b0;
            rsp.rdata <= 16'h0000;
            if (cmd.valid) begin
                case (cmd.code)
                    CMD_WARN_LIMIT: begin
                        rsp.ack <= 1'b1;
                        rsp.rdata <= input_low_warning_threshold;
                    end
                    CMD_FAULT_LIMIT: begin
                        rsp.ack <= 1'b1;
                        rsp.rdata <= input_low_fault_threshold;
                    end
                    CMD_FAULT_REACTION: begin
                        rsp.ack <= 1'b1;
                        rsp.rdata <= {8'h00, input_low_fault_reaction};
                    end
                    default: ;
                endcase
            end
        end
    end

    // raw codes compared: limits and measurement share one exponent
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vin_fault <= 1'b0;
            warning_flag <= 1'b0;
            ratio_regulation_active <= 1'b0;
        end else begin
            vin_fault <= vin_level < input_low_fault_threshold;
            warning_flag <= vin_level < input_low_warning_threshold;
            ratio_regulation_active <= ratio_regulation_enable
                && (vin_level < input_low_warning_threshold);
        end
    end

    uv_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(timer_start),
        .unit_cycles(delay_unit_cycles),
        .shift(delay_shift),
        .done(timer_done),
        .busy()
    );

    always_comb begin
        next_state = state;
        timer_start = 1'b0;
        if (!on_command) begin
            next_state = ST_OFF;
        end else begin
            case (state)
                ST_RUN: begin
                    if (vin_fault) begin
                        case (reaction)
                            REACT_IGNORE: next_state = ST_RUN;
                            REACT_DELAYED: begin
                                next_state = ST_HOLD;
                                timer_start = 1'b1;
                            end
                            REACT_DISABLE_RETRY: begin
                                if (retries == RETRY_NONE) begin
                                    next_state = ST_LATCH;
                                end else begin
                                    next_state = ST_WAIT;
                                    timer_start = 1'b1;
                                end
                            end
                            default: next_state = ST_LATCH;
                        endcase
                    end
                end
                ST_HOLD: begin
                    if (!vin_fault) begin
                        next_state = ST_RUN;
                    end else if (timer_done) begin
                        if (retries == RETRY_NONE) begin
                            next_state = ST_LATCH;
                        end else begin
                            next_state = ST_WAIT;
                            timer_start = 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (other_fault_shutdown) begin
                        next_state = ST_LATCH;
                    end else if (timer_done) begin
                        if (!vin_fault) begin
                            next_state = ST_RUN;
                        end else if (!retries_forever(retries) && attempts_left == 3'h1) begin
                            next_state = ST_LATCH;
                        end else begin
                            timer_start = 1'b1;
                        end
                    end
                end
                ST_LATCH: begin
                    if (fault_clear) begin
                        next_state = ST_RUN;
                    end
                end
                ST_OFF: next_state = ST_RUN;
                default: next_state = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // attempt count loads on entry to the restart wait, drops at every wait timer expiry (failed or not) unless retrying forever
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            attempts_left <= 3'h0;
        end else if (state != ST_WAIT && next_state == ST_WAIT) begin
            attempts_left <= retries;
        end else if (state == ST_WAIT && timer_done && !retries_forever(retries)) begin
            attempts_left <= attempts_left - 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_enable <= 1'b0;
            latched_off <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            power_enable <= (next_state == ST_RUN) || (next_state == ST_HOLD);
            latched_off <= next_state == ST_LATCH;
            // set wins over a clear in the same cycle
            if (vin_fault && reaction != REACT_IGNORE) begin
                fault_flag <= 1'b1;
            end else if (fault_clear) begin
                fault_flag <= 1'b0;
            end
        end
    end
endmodule

// File: verilog/uv_fault_pkg.sv
package uv_fault_pkg;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h58;
    localparam logic [7:0] CMD_FAULT_LIMIT = 8'h59;
    localparam logic [7:0] CMD_FAULT_REACTION = 8'h5a;

    localparam logic [15:0] WARN_LIMIT_RESET = 16'h0000;
    localparam logic [15:0] FAULT_LIMIT_RESET = 16'h0000;
    localparam logic [7:0] REACTION_RESET = 8'hc0;

    localparam int REACT_HI = 7;
    localparam int REACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    localparam logic [1:0] REACT_IGNORE = 2'h0;
    localparam logic [1:0] REACT_DELAYED = 2'h1;
    localparam logic [1:0] REACT_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] REACT_LATCH_OFF = 2'h3;

    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    localparam int DEF_UNIT_W = 16;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HOLD = 3'b001,
        ST_WAIT = 3'b010,
        ST_LATCH = 3'b011,
        ST_OFF = 3'b100
    } uv_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [15:0] rdata;
    } rsp_t;
endpackage

// File: verilog/uv_delay_timer.sv
`timescale 1ns/1ps
module uv_delay_timer #(
    parameter int UNIT_W = uv_fault_pkg::DEF_UNIT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [UNIT_W-1:0] unit_cycles,
    input wire logic [2:0] shift,
    output logic done,
    output logic busy
);
    import uv_fault_pkg::*;

    logic [UNIT_W-1:0] cyc;
    logic [7:0] units;
    logic [7:0] last_unit;
    logic [UNIT_W-1:0] last_cyc;

    generate
        if (UNIT_W < 1) begin : g_bad_width
            $error("uv_delay_timer: UNIT_W must be at least 1");
        end
    endgenerate

    // 2^shift units, 0 gives 1 and 7 gives 128
    assign last_unit = 8'((9'h001 << shift) - 9'h001);
    // a zero unit length is taken as one cycle so the timer always ends
    assign last_cyc = (unit_cycles == '0) ? '0 : unit_cycles - 1'b1;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc <= '0;
            units <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cyc <= '0;
                units <= 8'h00;
                busy <= 1'b1;
            end else if (busy) begin
                if (cyc == last_cyc) begin
                    cyc <= '0;
                    if (units == last_unit) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        units <= units + 8'h01;
                    end
                end else begin
                    cyc <= cyc + 1'b1;
                end
            end
        end
    end
endmodule

// File: bench/uv_fault_chk_sva.sv
`timescale 1ns/1ps
module uv_fault_chk
    import uv_fault_pkg::*;
#(
    parameter int UNIT_W = DEF_UNIT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire uv_fault_pkg::cmd_t cmd,
    input wire uv_fault_pkg::rsp_t rsp,
    input wire logic [15:0] vin_level,
    input wire logic [UNIT_W-1:0] delay_unit_cycles,
    input wire logic ratio_regulation_enable,
    input wire logic on_command,
    input wire logic clear_faults,
    input wire logic status_clear,
    input wire logic other_fault_shutdown,
    input wire logic power_enable,
    input wire logic warning_flag,
    input wire logic fault_flag,
    input wire logic ratio_regulation_active,
    input wire logic latched_off
);
    logic [15:0] wthr;
    logic [15:0] fthr;
    logic [1:0] react;
    logic [2:0] retry;
    wire wr = cmd.valid && cmd.write;
    wire known = cmd.code inside {CMD_WARN_LIMIT, CMD_FAULT_LIMIT, CMD_FAULT_REACTION};
    // shadow limits, so the flags can be judged from port traffic alone
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wthr <= WARN_LIMIT_RESET;
            fthr <= FAULT_LIMIT_RESET;
            react <= REACTION_RESET[REACT_HI:REACT_LO];
            retry <= REACTION_RESET[RETRY_HI:RETRY_LO];
        end else if (wr) begin
            case (cmd.code)
                CMD_WARN_LIMIT: wthr <= cmd.wdata;
                CMD_FAULT_LIMIT: fthr <= cmd.wdata;
                CMD_FAULT_REACTION: begin
                    react <= cmd.wdata[REACT_HI:REACT_LO];
                    retry <= cmd.wdata[RETRY_HI:RETRY_LO];
                end
                default: ;
            endcase
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence uv_low(logic [1:0] r);
        react == r && vin_level < fthr;
    endsequence
    // no clear or off command inside the window, those may legally restart
    sequence no_retry_low;
        react == REACT_DISABLE_RETRY && retry == RETRY_NONE && vin_level < fthr
            && on_command && !clear_faults && !status_clear;
    endsequence
    rsp_ok_a: assert property ((cmd.valid && known) |=> rsp.valid && rsp.ack)
        else $error("known command not answered");
    rsp_idle_a: assert property (!cmd.valid |=> !rsp.valid)
        else $error("answer without request");
    unmapped_a: assert property ((cmd.valid && !known) |=> !rsp.ack && rsp.rdata == 16'h0000)
        else $error("unmapped command accepted");
    warn_flag_a: assert property (warning_flag == ($past(vin_level) < $past(wthr)))
        else $error("warning flag wrong");
    ratio_a: assert property (ratio_regulation_active ==
        $past(ratio_regulation_enable && vin_level < wthr))
        else $error("ratio regulation wrong");
    ignore_a: assert property ((react == REACT_IGNORE && power_enable && on_command && !wr)
        |=> power_enable)
        else $error("output dropped while ignoring");
    disable_a: assert property (uv_low(REACT_DISABLE_RETRY) [*3] |-> !power_enable)
        else $error("output not disabled");
    latch_off_a: assert property (no_retry_low [*3] |-> latched_off && !power_enable)
        else $error("no-retry fault did not latch off");
    latch_hold_a: assert property ((latched_off && on_command && !clear_faults
        && !status_clear) |=> latched_off)
        else $error("latch left without clear");
    flag_a: assert property ((vin_level < fthr && react != REACT_IGNORE && power_enable)
        [*2] |=> fault_flag)
        else $error("fault flag not set");
endmodule
bind input_undervoltage_fault_handler uv_fault_chk #(.UNIT_W(UNIT_W)) chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cmd(cmd),
    .rsp(rsp),
    .vin_level(vin_level),
    .delay_unit_cycles(delay_unit_cycles),
    .ratio_regulation_enable(ratio_regulation_enable),
    .on_command(on_command),
    .clear_faults(clear_faults),
    .status_clear(status_clear),
    .other_fault_shutdown(other_fault_shutdown),
    .power_enable(power_enable),
    .warning_flag(warning_flag),
    .fault_flag(fault_flag),
    .ratio_regulation_active(ratio_regulation_active),
    .latched_off(latched_off)
);

// File: bench/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic core_clk,
    output uv_fault_pkg::cmd_t cmd,
    input wire uv_fault_pkg::rsp_t rsp
);
    import uv_fault_pkg::*;
    initial cmd = '0;
    // one-cycle request; the answer is registered, so read it just after the taking edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        output logic a, output logic [15:0] q);
        @(posedge core_clk);
        cmd <= '{valid: 1'b1, write: w, code: c, wdata: d};
        @(posedge core_clk);
        cmd <= '0;
        #1;
        a = rsp.valid && rsp.ack;
        q = rsp.rdata;
    endtask
endmodule

// File: bench/tb_input_undervoltage_fault_handler.sv
`timescale 1ns/1ps
module tb_input_undervoltage_fault_handler;
    import uv_fault_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    cmd_t cmd;
    rsp_t rsp;
    logic [15:0] vin_level = 16'hffff;
    logic [3:0] delay_unit_cycles = 4'h3;
    logic ratio_regulation_enable = 1'b0;
    logic on_command = 1'b1;
    logic clear_faults = 1'b0;
    logic status_clear = 1'b0;
    logic other_fault_shutdown = 1'b0;
    logic power_enable, warning_flag, fault_flag, ratio_regulation_active, latched_off;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] seed = 8'h30;
    logic [15:0] model [3];
    logic [7:0] codes [3] = '{CMD_WARN_LIMIT, CMD_FAULT_LIMIT, CMD_FAULT_REACTION};
    logic [7:0] cases [8] = '{8'h00, 8'h80, 8'h91, 8'hb0, 8'hc0, 8'h4b, 8'h47, 8'hb8};
    always #2.5 core_clk = ~core_clk;
    input_undervoltage_fault_handler #(.UNIT_W(4)) uut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .cmd(cmd),
        .rsp(rsp),
        .vin_level(vin_level),
        .delay_unit_cycles(delay_unit_cycles),
        .ratio_regulation_enable(ratio_regulation_enable),
        .on_command(on_command),
        .clear_faults(clear_faults),
        .status_clear(status_clear),
        .other_fault_shutdown(other_fault_shutdown),
        .power_enable(power_enable),
        .warning_flag(warning_flag),
        .fault_flag(fault_flag),
        .ratio_regulation_active(ratio_regulation_active),
        .latched_off(latched_off)
    );
    pmbus_host_model host (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        input logic ea, input logic [15:0] eq);
        logic a;
        logic [15:0] q;
        host.xfer(w, c, d, a, q);
        chk("ack", {15'h0, ea}, {15'h0, a});
        chk("rdata", eq, q);
    endtask
    task automatic conclude;
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        conclude;
    end
    initial begin
        int span, n, exp, po, tp, tl, unit;
        logic [7:0] b;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        model = '{WARN_LIMIT_RESET, FAULT_LIMIT_RESET, {8'h00, REACTION_RESET}};
        for (int i = 0; i < 9; i++) begin
            if (i / 3 == 1) begin
                seed = lfsr(seed);
                b = lfsr(seed);
                // a write answers with the word it replaces
                xfer(1'b1, codes[i % 3], {seed, b}, 1'b1, model[i % 3]);
                model[i % 3] = (i % 3 == 2) ? {8'h00, b} : {seed, b};
            end else begin
                xfer(1'b0, codes[i % 3], 16'h0000, 1'b1, model[i % 3]);
            end
        end
        xfer(1'b1, 8'h5b, 16'hffff, 1'b0, 16'h0000);
        xfer(1'b0, 8'h5b, 16'h0000, 1'b0, 16'h0000);
        xfer(1'b0, CMD_FAULT_REACTION, 16'h0000, 1'b1, model[2]);
        xfer(1'b1, CMD_WARN_LIMIT, 16'h8000, 1'b1, model[0]);
        model[0] = 16'h8000;
        xfer(1'b1, CMD_FAULT_LIMIT, 16'h4000, 1'b1, model[1]);
        model[1] = 16'h4000;
        @(posedge core_clk);
        vin_level <= 16'h7000;
        ratio_regulation_enable <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("warning", 1, warning_flag);
        chk("ratio", 1, ratio_regulation_active);
        foreach (cases[i]) begin
            b = cases[i];
            n = b[5:3];
            // unit length varies per case so the delay input is really used
            unit = 2 + i % 3;
            span = (1 << b[2:0]) * unit;
            po = 1 + (b[7:6] == REACT_DELAYED ? span + 1 : 0);
            exp = po + (b[7:6] == REACT_LATCH_OFF ? 0 : n * (span + 1));
            tp = -1;
            tl = -1;
            xfer(1'b1, CMD_FAULT_REACTION, {8'h00, b}, 1'b1, model[2]);
            model[2] = {8'h00, b};
            @(posedge core_clk);
            vin_level <= 16'h1000;
            delay_unit_cycles <= 4'(unit);
            for (int c = 0; c < 1000 && tl < 0; c++) begin
                @(posedge core_clk);
                // retry-forever only ends on another shutdown cause
                if (c == 300 && n == 7) other_fault_shutdown <= 1'b1;
                #1;
                if (!power_enable && tp < 0) tp = c;
                if (latched_off) tl = c;
            end
            chk("fault_flag", 16'(b[7:6] != REACT_IGNORE), 16'(fault_flag));
            if (b[7:6] == REACT_IGNORE) begin
                chk("ignored", 16'hffff, tp[15:0]);
            end else begin
                chk("off_time", 1, tp >= po && tp <= po + 2);
                if (n == 7) chk("forever", 1, tl > 300 && tl < 304 + span);
                else chk("latch_time", 1, tl >= exp - n - 1 && tl <= exp + 2 * n + 2);
            end
            @(posedge core_clk);
            vin_level <= 16'h9000;
            other_fault_shutdown <= 1'b0;
            repeat (2) @(posedge core_clk);
            clear_faults <= (i % 3 == 0);
            status_clear <= (i % 3 == 1);
            on_command <= (i % 3 != 2);
            @(posedge core_clk);
            clear_faults <= 1'b0;
            status_clear <= 1'b0;
            on_command <= 1'b1;
            repeat (3) @(posedge core_clk);
            #1;
            chk("restored", 1, power_enable);
            chk("unlatched", 0, latched_off);
        end
        conclude;
    end
endmodule
